/* tpwm_defines.vh */
// register offsets, field positions, reset values and sizes of the pwm timer
`ifndef TPWM_DEFINES_VH
`define TPWM_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TPWM_ADDR_W 5
`define TPWM_OFF_CTRL1 5'h00
`define TPWM_OFF_CTRL23 5'h01
`define TPWM_OFF_IRQ_EN 5'h02
`define TPWM_OFF_FLAGS 5'h03
`define TPWM_CH_BASE 5'h08
`define TPWM_CH_STRIDE 5'h08
`define TPWM_SUB_PERIOD_LO 3'h0
`define TPWM_SUB_PERIOD_HI 3'h1
`define TPWM_SUB_DUTY_LO 3'h2
`define TPWM_SUB_DUTY_HI 3'h3
`define TPWM_SUB_COUNT_LO 3'h4
`define TPWM_SUB_COUNT_HI 3'h5
`define TPWM_SUB_LATCH_LO 3'h6
`define TPWM_SUB_LATCH_HI 3'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TPWM_C1_OUT3_EN 7
`define TPWM_C1_OUT2_EN 6
`define TPWM_C1_OUT1_EN 5
`define TPWM_C1_ZERO 4
`define TPWM_C1_CNT1_EN 3
`define TPWM_C1_SEL1_HI 2
`define TPWM_C1_SEL1_LO 0
`define TPWM_C23_CNT3_EN 7
`define TPWM_C23_CNT2_EN 6
`define TPWM_C23_SEL3_HI 5
`define TPWM_C23_SEL3_LO 3
`define TPWM_C23_SEL2_HI 2
`define TPWM_C23_SEL2_LO 0

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define TPWM_CTRL_RESET 8'h00
`define TPWM_CNT_W 10
`define TPWM_DIV_W 8
`define TPWM_CHANNELS 3

`endif

/* tpwm_channel.v */
// one pwm channel: 10-bit counter, period compare, duty latch, output
`timescale 1ns/1ps
module tpwm_channel #(
  parameter CNT_W = 10
) (
  input wire clk,
  input wire arst_n,
  input wire tick,
  input wire [CNT_W-1:0] period,
  input wire [CNT_W-1:0] duty_buffer,
  output reg [CNT_W-1:0] channel_counter,
  output reg [CNT_W-1:0] duty_latch,
  output reg pwm_level,
  output reg match_pulse
);

  wire [CNT_W:0] count_sum;
  wire [CNT_W-1:0] count_inc;
  wire at_period;

  assign count_sum = {1'b0, channel_counter} + {{CNT_W{1'b0}}, 1'b1};
  assign count_inc = count_sum[CNT_W-1:0];
  assign at_period = (channel_counter == period);

  // ----------------------------------------------------------------
  // counter, duty latch and level
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      channel_counter <= {CNT_W{1'b0}};
      duty_latch <= {CNT_W{1'b0}};
      pwm_level <= 1'b0;
      match_pulse <= 1'b0;
    end
    else
    begin
      match_pulse <= 1'b0;
      if (tick)
      begin
        if (at_period)
        begin
          channel_counter <= {CNT_W{1'b0}};
          duty_latch <= duty_buffer;
          pwm_level <= (duty_buffer != {CNT_W{1'b0}});
          match_pulse <= 1'b1;
        end
        else
        begin
          channel_counter <= count_inc;
          if (count_inc == duty_latch)
            pwm_level <= 1'b0;
        end
      end
    end
  end

endmodule

/* tpwm_top.v */
// three-channel pwm timer with prescalers and a byte register port
//
// Functional notes
// - three independent pwm outputs, ten bits of period and duty each
// - each counter is a 10-bit up-counter behind a prescaler, read-only
// - clearing a counter enable stops that counter
// - on period match: clear counter, output high, latch duty, set flag
// - a latched duty of zero keeps the output low
// - period equals period value plus one, times clock and prescale
// - counter equal to latched duty drives the output low
// - duty buffer writable anytime, latched only at period match
// - high time equals duty times clock period and prescale ratio
// - counters halt in sleep unless a conversion is running
// - three-bit select gives ratios 1 to 256; reset clears it
// - counter counts to period then restarts from zero
// - control one: output enables 7..5, bit 4 zero, enable, select
// - control two: enables at 7 and 6, selects at 5..3 and 2..0
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "tpwm_defines.vh"
module tpwm_top #(
  parameter CNT_W = `TPWM_CNT_W,
  parameter DIV_W = `TPWM_DIV_W
) (
  input wire clk,
  input wire arst_n,
  input wire [`TPWM_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire sleep_mode,
  input wire adc_running,
  output wire [2:0] channel_output,
  output wire [2:0] channel_output_oe,
  output wire irq
);

  // ----------------------------------------------------------------
  // prescale decode
  // ----------------------------------------------------------------
  function [DIV_W-1:0] prescale_mask;
    input [2:0] sel;
    reg [7:0] ones;
    begin
      // no 1:32 step: 1:16 jumps straight to 1:64
      case (sel)
        3'h0: ones = 8'h00;
        3'h1: ones = 8'h01;
        3'h2: ones = 8'h03;
        3'h3: ones = 8'h07;
        3'h4: ones = 8'h0F;
        3'h5: ones = 8'h3F;
        3'h6: ones = 8'h7F;
        default: ones = 8'hFF;
      endcase
      prescale_mask = ones[DIV_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // register address decode
  // ----------------------------------------------------------------
  function addr_is;
    input [`TPWM_ADDR_W-1:0] addr;
    input [`TPWM_ADDR_W-1:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg [7:0] pwm_output_and_timer1_control;
  reg [7:0] timer2_timer3_control;
  reg [2:0] interrupt_enable_register;
  reg [2:0] channel_period_flag;

  wire counter1_enable;
  wire counter2_enable;
  wire counter3_enable;
  wire output1_enable;
  wire output2_enable;
  wire output3_enable;
  wire [2:0] counter1_prescale_sel;
  wire [2:0] counter2_prescale_sel;
  wire [2:0] counter3_prescale_sel;

  assign output3_enable = pwm_output_and_timer1_control[`TPWM_C1_OUT3_EN];
  assign output2_enable = pwm_output_and_timer1_control[`TPWM_C1_OUT2_EN];
  assign output1_enable = pwm_output_and_timer1_control[`TPWM_C1_OUT1_EN];
  assign counter1_enable = pwm_output_and_timer1_control[`TPWM_C1_CNT1_EN];
  assign counter1_prescale_sel =
    pwm_output_and_timer1_control[`TPWM_C1_SEL1_HI:`TPWM_C1_SEL1_LO];
  assign counter3_enable = timer2_timer3_control[`TPWM_C23_CNT3_EN];
  assign counter2_enable = timer2_timer3_control[`TPWM_C23_CNT2_EN];
  assign counter3_prescale_sel =
    timer2_timer3_control[`TPWM_C23_SEL3_HI:`TPWM_C23_SEL3_LO];
  assign counter2_prescale_sel =
    timer2_timer3_control[`TPWM_C23_SEL2_HI:`TPWM_C23_SEL2_LO];

  wire [2:0] cnt_enable;
  wire [2:0] out_enable;
  wire [8:0] sel_flat;

  assign cnt_enable = {counter3_enable, counter2_enable, counter1_enable};
  assign out_enable = {output3_enable, output2_enable, output1_enable};
  assign sel_flat = {counter3_prescale_sel, counter2_prescale_sel,
    counter1_prescale_sel};

  // sleep and adc status come from core logic on this clock
  wire halted;
  assign halted = sleep_mode & ~adc_running;

  wire ctrl1_hit;
  wire ctrl23_hit;
  wire irq_en_hit;
  wire flags_hit;

  assign ctrl1_hit = reg_wr && addr_is(reg_addr, `TPWM_OFF_CTRL1);
  assign ctrl23_hit = reg_wr && addr_is(reg_addr, `TPWM_OFF_CTRL23);
  assign irq_en_hit = reg_wr && addr_is(reg_addr, `TPWM_OFF_IRQ_EN);
  assign flags_hit = reg_wr && addr_is(reg_addr, `TPWM_OFF_FLAGS);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_output_and_timer1_control <= `TPWM_CTRL_RESET;
      timer2_timer3_control <= `TPWM_CTRL_RESET;
      interrupt_enable_register <= 3'h0;
    end
    else
    begin
      if (ctrl1_hit)
      begin
        // bit 4 is held at zero
        pwm_output_and_timer1_control <= reg_wdata & 8'hEF;
      end
      if (ctrl23_hit)
        timer2_timer3_control <= reg_wdata;
      if (irq_en_hit)
        interrupt_enable_register <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // channels: prescaler, period and duty registers, counter
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] count_w [0:2];
  wire [CNT_W-1:0] latch_w [0:2];
  wire [CNT_W-1:0] period_w [0:2];
  wire [CNT_W-1:0] duty_w [0:2];
  wire [2:0] match_w;
  wire [2:0] level_w;

  genvar i;
  generate
    for (i = 0; i < `TPWM_CHANNELS; i = i + 1)
    begin : g_ch
      localparam [31:0] BASE_FULL =
        `TPWM_CH_BASE + i * `TPWM_CH_STRIDE;
      localparam [`TPWM_ADDR_W-1:0] BASE = BASE_FULL[`TPWM_ADDR_W-1:0];
      reg [DIV_W-1:0] divider;
      reg [CNT_W-1:0] period_register;
      reg [CNT_W-1:0] duty_buffer;
      wire run;
      wire [DIV_W-1:0] mask;
      wire tick;
      wire [DIV_W:0] div_sum;
      wire ch_hit;

      assign run = cnt_enable[i] & ~halted;
      assign mask = prescale_mask(sel_flat[3*i+2:3*i]);
      assign tick = run && ((divider & mask) == mask);
      assign div_sum = {1'b0, divider} + {{DIV_W{1'b0}}, 1'b1};
      assign ch_hit = reg_wr && (reg_addr[`TPWM_ADDR_W-1:3] == BASE[4:3]);

      // free-running divider, frozen while the channel is stopped
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          divider <= {DIV_W{1'b0}};
        else if (run)
          divider <= div_sum[DIV_W-1:0];
      end

      // period and duty buffer written as low and high bytes
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          period_register <= {CNT_W{1'b0}};
          duty_buffer <= {CNT_W{1'b0}};
        end
        else if (ch_hit)
        begin
          case (reg_addr[2:0])
            `TPWM_SUB_PERIOD_LO: period_register[7:0] <= reg_wdata;
            `TPWM_SUB_PERIOD_HI:
              period_register[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
            `TPWM_SUB_DUTY_LO: duty_buffer[7:0] <= reg_wdata;
            `TPWM_SUB_DUTY_HI:
              duty_buffer[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
            default: ;
          endcase
        end
      end

      assign period_w[i] = period_register;
      assign duty_w[i] = duty_buffer;

      tpwm_channel #(
        .CNT_W(CNT_W)
      ) u_channel (
        .clk(clk),
        .arst_n(arst_n),
        .tick(tick),
        .period(period_register),
        .duty_buffer(duty_buffer),
        .channel_counter(count_w[i]),
        .duty_latch(latch_w[i]),
        .pwm_level(level_w[i]),
        .match_pulse(match_w[i])
      );

      // output gated by its enable; disabled means plain timer
      assign channel_output[i] = level_w[i] & out_enable[i];
      assign channel_output_oe[i] = out_enable[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // period flags: write one to clear, a new match wins over the clear
  // ----------------------------------------------------------------
  wire [2:0] flag_clear;
  assign flag_clear = flags_hit ? reg_wdata[2:0] : 3'h0;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      channel_period_flag <= 3'h0;
    else
      channel_period_flag <= (channel_period_flag & ~flag_clear) |
        match_w;
  end

  assign irq = |(channel_period_flag & interrupt_enable_register);

  // ----------------------------------------------------------------
  // read port, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;
  reg [1:0] rd_ch;
  reg [CNT_W-1:0] rd_word;

  // counter and latch words have no write path

  always @*
  begin
    next_rdata = 8'h00;
    rd_ch = reg_addr[4:3] - 2'h1;
    rd_word = {CNT_W{1'b0}};
    case (reg_addr)
      `TPWM_OFF_CTRL1: next_rdata = pwm_output_and_timer1_control;
      `TPWM_OFF_CTRL23: next_rdata = timer2_timer3_control;
      `TPWM_OFF_IRQ_EN: next_rdata = {5'h00, interrupt_enable_register};
      `TPWM_OFF_FLAGS: next_rdata = {5'h00, channel_period_flag};
      default:
      begin
        if (reg_addr[4:3] != 2'h0)
        begin
          case (reg_addr[2:1])
            2'h0: rd_word = period_w[rd_ch];
            2'h1: rd_word = duty_w[rd_ch];
            2'h2: rd_word = count_w[rd_ch];
            default: rd_word = latch_w[rd_ch];
          endcase
          if (reg_addr[0])
            next_rdata = {6'h00, rd_word[CNT_W-1:8]};
          else
            next_rdata = rd_word[7:0];
        end
      end
    endcase
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

endmodule

/* tpwm_sva.sv */
// port assertions for the pwm timer
`timescale 1ns/1ps
module tpwm_sva #(
  parameter CNT_W = 10,
  parameter DIV_W = 8
) (
  input logic clk,
  input logic arst_n,
  input logic [4:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic sleep_mode,
  input logic adc_running,
  input logic [2:0] channel_output,
  input logic [2:0] channel_output_oe,
  input logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_wr_ctrl;
    reg_wr && reg_addr == 5'h00;
  endsequence
  sequence s_rd_ctrl;
    reg_rd && reg_addr == 5'h00;
  endsequence
  property p_gate;
    (channel_output & ~channel_output_oe) == 3'h0;
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_bit4;
    s_rd_ctrl |=> reg_rdata[4] == 1'b0;
  endproperty
  property p_unmapped;
    reg_rd && reg_addr[4:2] == 3'h1 |=> reg_rdata == 8'h00;
  endproperty
  property p_oe_wr;
    s_wr_ctrl |=> channel_output_oe == $past(reg_wdata[7:5]);
  endproperty
  property p_oe_hold;
    !(reg_wr && reg_addr == 5'h00) |=> $stable(channel_output_oe);
  endproperty
  property p_readback;
    s_wr_ctrl ##1 s_rd_ctrl |=> reg_rdata == ($past(reg_wdata, 2) & 8'hEF);
  endproperty
  property p_hi;
    reg_rd && reg_addr >= 5'h08 && reg_addr[0] |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("pin high undriven");
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  a_bit4: assert property (p_bit4) else $error("bit 4 set");
  a_unmapped: assert property (p_unmapped) else $error("gap data");
  a_oe_wr: assert property (p_oe_wr) else $error("oe mismatch");
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  a_readback: assert property (p_readback) else $error("ctrl read");
  a_hi: assert property (p_hi) else $error("hi byte wide");
endmodule

/* tpwm_load.sv */
// load model on the pwm pins: measures high time and period
`timescale 1ns/1ps
module tpwm_load (
  input logic clk,
  input logic [2:0] pins,
  input logic [2:0] oe,
  output logic [2:0][15:0] hi_len,
  output logic [2:0][15:0] per_len
);
  logic [2:0] lvl;
  logic [2:0] prev;
  logic [2:0][15:0] run;
  logic [2:0][15:0] hcnt;
  // pull-down on each load
  assign lvl = pins & oe;
  initial
  begin
    prev = 3'h0;
    run = '0;
    hcnt = '0;
    hi_len = '0;
    per_len = '0;
  end
  always @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      prev[i] <= lvl[i];
      if (lvl[i] && !prev[i])
      begin
        per_len[i] <= run[i];
        run[i] <= 16'h0001;
        hcnt[i] <= 16'h0001;
      end
      else
      begin
        run[i] <= run[i] + 16'h0001;
        if (lvl[i])
          hcnt[i] <= hcnt[i] + 16'h0001;
        if (!lvl[i] && prev[i])
          hi_len[i] <= hcnt[i];
      end
    end
  end
endmodule

/* tb.sv */
// testbench for the pwm timer
`timescale 1ns/1ps
module tb;
  localparam int PER_V [3] = '{3, 3, 4};
  localparam int DUT_V [3] = '{2, 1, 3};
  localparam int RATIO [3] = '{1, 2, 4};
  logic clk;
  logic arst_n;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sleep_mode;
  logic adc_running;
  logic [2:0] channel_output;
  logic [2:0] channel_output_oe;
  logic irq;
  logic [2:0][15:0] hi_len;
  logic [2:0][15:0] per_len;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  int mismatches;
  int cmp_count;
  tpwm_top tpwm_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .adc_running(adc_running), .channel_output(channel_output),
    .channel_output_oe(channel_output_oe), .irq(irq));
  tpwm_load tpwm_load_i (.clk(clk), .pins(channel_output),
    .oe(channel_output_oe), .hi_len(hi_len), .per_len(per_len));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] w,
    output logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // two counter reads some cycles apart
  task automatic same(input logic [4:0] a, input logic exp);
    rd(a, rd_a);
    repeat (5) @(posedge clk);
    rd(a, rd_b);
    check(rd_a === rd_b, exp);
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    conclude();
  end
  initial
  begin
    arst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_mode = 1'b0;
    adc_running = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(5'h00, rd_a);
    check(rd_a, 8'h00);
    rd(5'h01, rd_a);
    check(rd_a, 8'h00);
    wr_rd(5'h00, 8'h10, rd_a);
    check(rd_a, 8'h00);
    rd(5'h05, rd_a);
    check(rd_a, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(5'h08 + 5'(8 * i), 8'(PER_V[i]));
      wr(5'h0A + 5'(8 * i), 8'(DUT_V[i]));
    end
    wr(5'h02, 8'h07);
    wr(5'h00, 8'hE8);
    wr(5'h01, 8'hD1);
    repeat (300) @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      check(per_len[i], 16'((PER_V[i] + 1) * RATIO[i]));
      check(hi_len[i], 16'(DUT_V[i] * RATIO[i]));
    end
    rd(5'h03, rd_a);
    check(rd_a, 8'h07);
    check(irq, 1'b1);
    wr(5'h02, 8'h00);
    #1;
    check(irq, 1'b0);
    rd(5'h00, rd_a);
    check(rd_a, 8'hE8);
    rd(5'h01, rd_a);
    check(rd_a, 8'hD1);
    wr(5'h0A, 8'h01);
    repeat (40) @(posedge clk);
    check(hi_len[0], 16'h0001);
    rd(5'h0E, rd_a);
    check(rd_a, 8'h01);
    wr(5'h0A, 8'h00);
    repeat (20) @(posedge clk);
    repeat (8)
    begin
      @(negedge clk);
      check(channel_output[0], 1'b0);
    end
    wr(5'h00, 8'h00);
    same(5'h0C, 1'b1);
    wr(5'h0C, ~rd_a);
    rd(5'h0C, rd_b);
    check(rd_b, rd_a);
    @(posedge clk);
    sleep_mode <= 1'b1;
    same(5'h1C, 1'b1);
    @(posedge clk);
    adc_running <= 1'b1;
    same(5'h1C, 1'b0);
    @(posedge clk);
    sleep_mode <= 1'b0;
    // slow ratios: 1:256 on channel two, 1:64 on channel three
    wr(5'h00, 8'hC0);
    wr(5'h01, 8'hEF);
    repeat (2600) @(posedge clk);
    check(per_len[1], 16'((PER_V[1] + 1) * 256));
    check(hi_len[1], 16'(DUT_V[1] * 256));
    check(per_len[2], 16'((PER_V[2] + 1) * 64));
    check(hi_len[2], 16'(DUT_V[2] * 64));
    wr(5'h01, 8'h2F);
    wr(5'h03, 8'h07);
    rd(5'h03, rd_a);
    check(rd_a, 8'h00);
    wr(5'h00, 8'h08);
    repeat (8)
    begin
      @(negedge clk);
      check(channel_output, 3'h0);
      check(channel_output_oe, 3'h0);
    end
    rd(5'h03, rd_a);
    check(rd_a, 8'h01);
    wr(5'h0B, 8'hFF);
    rd(5'h0B, rd_a);
    check(rd_a, 8'h03);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(5'h00, rd_a);
    check(rd_a, 8'h00);
    rd(5'h01, rd_a);
    check(rd_a, 8'h00);
    conclude();
  end
endmodule
bind tpwm_top tpwm_sva #(.CNT_W(CNT_W), .DIV_W(DIV_W)) tpwm_sva_i (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_mode(sleep_mode), .adc_running(adc_running),
  .channel_output(channel_output), .channel_output_oe(channel_output_oe),
  .irq(irq));
